// ===== hw/sclk_pkg.sv
// Constants and encodings for the system clock and low-power control block
// Notes on behaviour
// - With the output option set, the clock pin shows the internal clock, main/4 or sub/2.
// - The source select bit picks main oscillator over four when clear, sub over two when set.
// - The halt instruction stops both oscillators and holds the internal clock high.
// - During halt, timers 2 and 3 are cascaded and timer 2 counts the internal clock over eight.
// - On oscillation restart timer 2 is loaded with all ones and timer 3 with seven.
// - An enabled external or serial interrupt ends halt and restarts oscillation.
// - After restart or reset release the internal clock stays high until timer 3 overflows.
// - The gate instruction stops the internal clock high and leaves the oscillator running.
// - Gate mode ends at once on an enabled interrupt, with no stabilization wait; reset enters the wait.
// - Setting the main-stop bit stops the main oscillator; clearing it restarts it.
// - Gated on the sub clock, timer 3 overflow or any listed interrupt restarts the clock.
package sclk_pkg;
  localparam logic [1:0] SCLK_MAIN_DIV_HALF = 2'h1;
  localparam logic [7:0] SCLK_T2_LOAD = 8'hFF;
  localparam logic [7:0] SCLK_T3_LOAD = 8'h07;
  localparam logic [1:0] SCLK_PRE_LAST = 2'h3;
  typedef enum logic [3:0] {
    SCLK_RUN = 4'h1,
    SCLK_HALT = 4'h2,
    SCLK_STAB = 4'h4,
    SCLK_GATE = 4'h8
  } sclk_state_e;
endpackage

// ===== hw/sclk_ctrl.sv
// System clock generation, halt, gate and wake stabilization sequencing
`timescale 1ns/1ns
module sclk_ctrl
  import sclk_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic main_osc_input,
  input wire logic sub_osc_input,
  input wire logic clock_source_select_bit,
  input wire logic main_osc_stop_bit,
  input wire logic clock_out_option,
  input wire logic halt_oscillators_instruction,
  input wire logic clock_gate_instruction,
  input wire logic external_irq_one,
  input wire logic external_irq_two,
  input wire logic serial_a_irq,
  input wire logic serial_b_irq,
  input wire logic timer1_irq,
  input wire logic timer2_irq,
  input wire logic timer3_overflow,
  output logic sys_clk,
  output logic sys_clk_pin,
  output logic cpu_clk_enable,
  output logic main_osc_enable,
  output logic sub_osc_enable,
  output logic timer_cascade_force,
  output logic timer2_div8_select,
  output logic timer_stab_load,
  output logic [7:0] timer2_load_value,
  output logic [7:0] timer3_load_value,
  output logic [1:0] mode_state
);
  import sclk_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] main_sync_reg;
  logic [1:0] sub_sync_reg;
  logic main_last_reg;
  logic sub_last_reg;
  logic main_rise;
  logic sub_rise;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      main_sync_reg <= 2'h0;
      sub_sync_reg <= 2'h0;
      main_last_reg <= 1'b0;
      sub_last_reg <= 1'b0;
    end else begin
      main_sync_reg <= {main_sync_reg[0], main_osc_input};
      sub_sync_reg <= {sub_sync_reg[0], sub_osc_input};
      main_last_reg <= main_sync_reg[1];
      sub_last_reg <= sub_sync_reg[1];
    end
  end

  assign main_rise = main_sync_reg[1] & ~main_last_reg;
  assign sub_rise = sub_sync_reg[1] & ~sub_last_reg;

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  sclk_state_e state_reg;
  sclk_state_e state_next;
  logic wake_halt;
  logic wake_gate;

  assign wake_halt = external_irq_one | external_irq_two | serial_a_irq | serial_b_irq;
  // Sources arrive already gated by their enable bits inside the interrupt logic
  assign wake_gate = wake_halt | timer1_irq | timer2_irq | timer3_overflow;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SCLK_RUN: begin
        if (halt_oscillators_instruction) begin
          state_next = SCLK_HALT;
        end else if (clock_gate_instruction) begin
          state_next = SCLK_GATE;
        end
      end
      SCLK_HALT: begin
        if (wake_halt) begin
          state_next = SCLK_STAB;
        end
      end
      SCLK_STAB: begin
        if (timer3_overflow) begin
          state_next = SCLK_RUN;
        end
      end
      SCLK_GATE: begin
        if (wake_gate) begin
          state_next = SCLK_RUN;
        end
      end
      default: state_next = SCLK_STAB;
    endcase
  end

  // Reset enters the stabilization wait, as a wake from halt does
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= SCLK_STAB;
    end else begin
      state_reg <= state_next;
    end
  end

  // Timer preset pulse on reset and on every wake from halt
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_stab_load <= 1'b1;
    end else begin
      timer_stab_load <= (state_reg == SCLK_HALT) && wake_halt;
    end
  end

  assign timer2_load_value = SCLK_T2_LOAD;
  assign timer3_load_value = SCLK_T3_LOAD;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      timer_cascade_force <= 1'b0;
      timer2_div8_select <= 1'b0;
    end else begin
      // Kept through the wait so the cascade measures the restart interval
      timer_cascade_force <= (state_next == SCLK_HALT) || (state_next == SCLK_STAB);
      timer2_div8_select <= (state_next == SCLK_HALT) || (state_next == SCLK_STAB);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      main_osc_enable <= 1'b1;
      sub_osc_enable <= 1'b1;
    end else begin
      main_osc_enable <= (state_next != SCLK_HALT) && !main_osc_stop_bit;
      sub_osc_enable <= state_next != SCLK_HALT;
    end
  end

  // ----------------------------------------------------------------
  // Internal clock divider
  // ----------------------------------------------------------------
  logic src_sel_reg;
  logic [1:0] pre_reg;
  logic phi_reg;
  logic phi_tick;
  logic clock_runs;
  logic src_pending;

  // Main/4: toggle every second main edge; sub/2: toggle on every sub edge
  assign phi_tick = src_sel_reg ? sub_rise : (main_rise && pre_reg == SCLK_MAIN_DIV_HALF);
  assign clock_runs = state_reg == SCLK_RUN;
  assign src_pending = clock_source_select_bit != src_sel_reg;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_reg <= 2'h0;
    end else if (main_rise) begin
      pre_reg <= (pre_reg == SCLK_MAIN_DIV_HALF) ? 2'h0 : pre_reg + 2'h1;
    end
  end

  // Source changes at the end of a low phase, or while the clock is held high outside run, so no phase is cut short
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_sel_reg <= 1'b0;
    end else if (!phi_reg && phi_tick) begin
      src_sel_reg <= clock_source_select_bit;
    end else if (phi_reg && !clock_runs) begin
      src_sel_reg <= clock_source_select_bit;
    end
  end

  // A pending switch stretches the low phase until the new source ticks
  // Halted oscillators never tick, so halt forces the clock high at once
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phi_reg <= 1'b1;
    end else if (!clock_runs) begin
      if (!phi_reg && (phi_tick || state_reg == SCLK_HALT)) begin
        phi_reg <= 1'b1;
      end
    end else if (phi_tick && !(src_pending && !phi_reg)) begin
      phi_reg <= ~phi_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sys_clk <= 1'b1;
      sys_clk_pin <= 1'b0;
      cpu_clk_enable <= 1'b0;
    end else begin
      sys_clk <= phi_reg;
      sys_clk_pin <= clock_out_option & phi_reg;
      cpu_clk_enable <= clock_runs;
    end
  end

  assign mode_state = {state_reg[3] | state_reg[2], state_reg[3] | state_reg[1]};

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence halt_wake_s;
    state_reg == SCLK_HALT && wake_halt;
  endsequence

  chk_halt_osc_stop: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_RUN && halt_oscillators_instruction |=> ##1 !sub_osc_enable && !main_osc_enable)
    else $error("oscillators still enabled after halt");
  chk_halt_clk_high: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_HALT && $past(state_reg) == SCLK_HALT |=> sys_clk)
    else $error("internal clock low during halt");
  chk_wake_preload: assert property (@(posedge clk) disable iff (!rst_b)
    halt_wake_s |=> timer_stab_load && timer3_load_value == 8'h07 && timer2_load_value == 8'hFF)
    else $error("timer preset missing on wake");
  chk_halt_cascade: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_HALT |-> timer_cascade_force && timer2_div8_select)
    else $error("cascade not forced in halt");
  chk_stab_withhold: assert property (@(posedge clk) disable iff (!rst_b)
    halt_wake_s ##1 !timer3_overflow |=> !cpu_clk_enable)
    else $error("clock released before overflow");
  chk_gate_release: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_GATE && wake_gate |=> state_reg == SCLK_RUN ##1 cpu_clk_enable)
    else $error("gate release not immediate");
  chk_gate_osc_runs: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_GATE && !main_osc_stop_bit |-> ##1 main_osc_enable && sub_osc_enable)
    else $error("oscillator stopped in gate mode");
  chk_main_stop_bit: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == SCLK_RUN && main_osc_stop_bit && !halt_oscillators_instruction |=> !main_osc_enable)
    else $error("main oscillator not stopped by bit");
  chk_pin_option: assert property (@(posedge clk) disable iff (!rst_b)
    !clock_out_option |=> !sys_clk_pin)
    else $error("clock pin driven without option");
  chk_src_phase: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(src_sel_reg) |-> !phi_reg || !$past(clock_runs))
    else $error("source switched mid phase");
endmodule

// ===== sim/sclk_partner.sv
// Far-side model: oscillators and a shortened timer 2/3 cascade
`timescale 1ns/1ns
module sclk_partner #(parameter int STAB = 24) (
  input wire logic clk,
  input wire logic main_en,
  input wire logic sub_en,
  input wire logic cascade,
  input wire logic load,
  output logic main_osc = 1'b0,
  output logic sub_osc = 1'b0,
  output logic ovf = 1'b0
);
  int ph = 0;
  int cnt = 0;
  // A stopped oscillator freezes at its last level
  always @(posedge clk) begin
    ph <= (ph + 1) % 10;
    if (main_en && ph % 2 == 1) main_osc <= ~main_osc;
    if (sub_en && ph % 5 == 4) sub_osc <= ~sub_osc;
  end
  // Far shorter than the real cascade, to keep runs brief
  always @(posedge clk) begin
    ovf <= (cnt == 1) && cascade;
    if (load) cnt <= STAB;
    else if (cascade && cnt > 0) cnt <= cnt - 1;
  end
endmodule

// ===== sim/test_system_clock_and_low_power_control.sv
// Self-checking bench for the system clock and low-power control block
`timescale 1ns/1ns
module test_system_clock_and_low_power_control;
  import sclk_pkg::*;
  logic clk = 0, rst_b = 0, sel = 0, mstop = 0, opt = 0, hlt = 0, gte = 0;
  logic [6:0] irq = '0;
  logic mosc, sosc, ovf, sck, pin, cen, men, sen, casc, div8, load;
  logic [7:0] t2v, t3v;
  logic [1:0] st;
  int failures = 0, comparisons = 0;
  initial begin
    forever #50 clk = ~clk;
  end
  sclk_ctrl dut (.clk(clk), .rst_b(rst_b), .main_osc_input(mosc), .sub_osc_input(sosc),
    .clock_source_select_bit(sel), .main_osc_stop_bit(mstop), .clock_out_option(opt),
    .halt_oscillators_instruction(hlt), .clock_gate_instruction(gte),
    .external_irq_one(irq[0]), .external_irq_two(irq[1]), .serial_a_irq(irq[2]),
    .serial_b_irq(irq[3]), .timer1_irq(irq[4]), .timer2_irq(irq[5]),
    .timer3_overflow(irq[6] | ovf), .sys_clk(sck), .sys_clk_pin(pin), .cpu_clk_enable(cen),
    .main_osc_enable(men), .sub_osc_enable(sen), .timer_cascade_force(casc),
    .timer2_div8_select(div8), .timer_stab_load(load), .timer2_load_value(t2v),
    .timer3_load_value(t3v), .mode_state(st));
  sclk_partner partner (.clk(clk), .main_en(men), .sub_en(sen), .cascade(casc),
    .load(load), .main_osc(mosc), .sub_osc(sosc), .ovf(ovf));
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (st !== 2'h0 && n < 200) begin
      chk(cen, 1'b0, "cpu clock during stab");
      tick(1);
      n++;
    end
    chk(st, 2'h0, "run after stab");
    tick(1);
    chk(cen, 1'b1, "cpu clock back");
  endtask
  task automatic phases(input int n, output int mn, output int mx);
    int len;
    logic pv;
    len = -99; mn = 999; mx = 0; pv = sck;
    repeat (n) begin
      tick(1);
      len++;
      if (pin !== (sck & opt) && pin !== (pv & opt)) chk(pin, sck & opt, "clock pin");
      if (sck !== pv) begin
        if (len > 0) begin
          mn = len < mn ? len : mn;
          mx = len > mx ? len : mx;
        end
        len = 0;
      end
      pv = sck;
    end
  endtask
  task automatic reset_test();
    tick(1);
    chk(st, 2'h2, "stab after reset");
    chk(sck, 1'b1, "clock high in stab");
    chk(casc, 1'b1, "cascade in stab");
    chk(t2v, 8'hFF, "timer2 preset");
    chk(t3v, 8'h07, "timer3 preset");
    wait_run();
    $display("reset test done");
  endtask
  task automatic clock_test();
    int mn, mx;
    opt <= 1'b1;
    phases(80, mn, mx);
    chk(mn, 8, "main low/high");
    chk(mx, 8, "main phase max");
    @(posedge clk) sel <= 1'b1;
    phases(60, mn, mx);
    chk(mn >= 8, 1'b1, "switch to sub phase");
    phases(80, mn, mx);
    chk(mn, 10, "sub phase");
    chk(mx, 10, "sub phase max");
    @(posedge clk) mstop <= 1'b1;
    tick(3);
    chk(men, 1'b0, "main stopped");
    @(posedge clk) mstop <= 1'b0;
    opt <= 1'b0;
    tick(3);
    chk(men, 1'b1, "main restarted");
    phases(40, mn, mx);
    @(posedge clk) sel <= 1'b0;
    phases(80, mn, mx);
    chk(mn >= 8, 1'b1, "switch to main phase");
    $display("clock test done");
  endtask
  task automatic halt_wake(input int k);
    logic seen;
    @(posedge clk) hlt <= 1'b1;
    @(posedge clk) hlt <= 1'b0;
    tick(14);
    chk({st, men, sen, sck, cen}, 6'h12, "halted state");
    chk({casc, div8}, 2'h3, "cascade and div8");
    @(posedge clk) irq[4] <= 1'b1;
    @(posedge clk) irq[4] <= 1'b0;
    #1 chk(st, 2'h1, "timer1 ignored in halt");
    @(posedge clk) irq[k] <= 1'b1;
    @(posedge clk) irq[k] <= 1'b0;
    #1 chk(st, 2'h2, "halt wake to stab");
    seen = load;
    repeat (3) begin
      tick(1);
      seen |= load;
    end
    chk(seen, 1'b1, "timer preset strobe");
    chk({men, sen}, 2'h3, "oscillators restart");
    wait_run();
    $display("halt test %0d done", k);
  endtask
  task automatic gate_wake(input int k);
    @(posedge clk) gte <= 1'b1;
    @(posedge clk) gte <= 1'b0;
    tick(14);
    chk({st, sck, cen}, 4'hE, "gated state");
    chk(sel ? sen : men, 1'b1, "oscillator kept");
    @(posedge clk) irq[k] <= 1'b1;
    @(posedge clk) irq[k] <= 1'b0;
    #1 chk(st, 2'h0, "immediate resume");
    tick(1);
    chk(cen, 1'b1, "cpu clock resumed");
    $display("gate test %0d done", k);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    reset_test();
    clock_test();
    for (int k = 0; k < 4; k++) halt_wake(k);
    gate_wake(0);
    @(posedge clk) sel <= 1'b1;
    for (int k = 0; k < 7; k++) gate_wake(k);
    give_verdict();
  end
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule
